/* File: lc_pkg.sv */
// Shared constants and check functions for the link check block
package lc_pkg;

  // ****************************************
  // Check generators
  // ****************************************
  // Reflected forms of x^8+x^5+x^4+1 and x^16+x^15+x^2+1, LSB-first shifting
  localparam logic [7:0] CRC8_POLY_REV = 8'h8c;
  localparam logic [15:0] CRC16_POLY_REV = 16'ha001;
  localparam logic [7:0] CRC8_CLEAR = 8'h00;
  localparam logic [15:0] CRC16_CLEAR = 16'h0000;

  // ****************************************
  // Command codes, offsets and counts
  // ****************************************
  localparam logic [7:0] CMD_WRITE_PAD = 8'h0f;
  localparam logic [7:0] CMD_READ_PAD = 8'haa;
  localparam logic [7:0] CMD_SIGNED_PAGE = 8'ha5;
  localparam logic [7:0] CMD_HASH = 8'h33;
  localparam logic [7:0] CMD_READ_ID = 8'h96;
  localparam logic [4:0] PAD_LAST_OFFSET = 5'h1f;
  localparam logic [2:0] ID_CHECK_INDEX = 3'h7;
  localparam logic [2:0] COUNTER_LAST_INDEX = 3'h7;
  localparam logic [2:0] CHECK_HIGH_INDEX = 3'h1;
  localparam logic [7:0] IDLE_READ_BYTE = 8'hff;
  localparam logic [7:0] CONCEAL_BYTE = 8'hff;

  // ****************************************
  // Byte-wise check updates
  // ****************************************
  // Shift one byte into the 8-bit check, least significant bit first
  function automatic logic [7:0] crc8_byte(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] r;
    logic fb;
    r = c;
    for (int i = 0; i < 8; i++)
    begin
      fb = r[0] ^ d[i];
      r = r >> 1;
      if (fb)
        r = r ^ CRC8_POLY_REV;
    end
    return r;
  endfunction

  // Shift one byte into the 16-bit check, least significant bit first
  function automatic logic [15:0] crc16_byte(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    logic fb;
    r = c;
    for (int i = 0; i < 8; i++)
    begin
      fb = r[0] ^ d[i];
      r = r >> 1;
      if (fb)
        r = r ^ CRC16_POLY_REV;
    end
    return r;
  endfunction

endpackage

/* File: lc_link_if.sv */
// Byte-level link between bus master end and token end
`timescale 1ns/1ps
`default_nettype none

interface lc_link_if;
  logic bus_reset; // Master: frame abort, one-cycle pulse
  logic m2s_valid; // Master: byte written to token
  logic [7:0] m2s_byte; // Master: written byte
  logic rd_req; // Master: asks for one byte
  logic s2m_valid; // Token: answer to rd_req
  logic [7:0] s2m_byte; // Token: answered byte

  modport master (output bus_reset, output m2s_valid, output m2s_byte, output rd_req,
                  input s2m_valid, input s2m_byte);
  modport token (input bus_reset, input m2s_valid, input m2s_byte, input rd_req,
                 output s2m_valid, output s2m_byte);
endinterface

`default_nettype wire

/* File: lc_token.sv */
// Token end: identity check for identity frames, frame check for pad, page and hash frames
`timescale 1ns/1ps
`default_nettype none

module lc_token (
  input wire logic sys_clk, // 200 MHz clock
  input wire logic resetn, // Async reset, active low
  lc_link_if.token lk, // Link to master
  input wire logic [55:0] id_serial, // Lower seven identity bytes
  input wire logic conceal_flag, // Pad contents hidden
  input wire logic [7:0] es_byte, // Ending/status byte
  input wire logic [7:0] sp_rdata, // Pad byte at sp_addr
  input wire logic [7:0] mem_rdata, // Page byte at mem_addr
  input wire logic [31:0] page_count, // Page write-cycle counter
  input wire logic [31:0] secret_count, // Secret write-cycle counter
  output var logic [4:0] sp_addr, // Pad offset being read
  output var logic sp_we, // Pad write strobe
  output var logic [4:0] sp_waddr, // Pad write offset
  output var logic [7:0] sp_wdata, // Pad write byte
  output var logic [15:0] mem_addr, // Page byte address
  output var logic hash_go, // Hash start pulse
  output var logic [7:0] hash_ctrl // Hash control byte
);

  // ****************************************
  // State and working registers
  // ****************************************
  typedef enum {
    ST_IDLE, ST_TA_LO, ST_TA_HI, ST_WR_DATA, ST_RD_ES, ST_RD_DATA,
    ST_PG_DATA, ST_PG_CNT, ST_HS_CTRL, ST_SEND_CRC, ST_ID_SEND, ST_DONE
  } lc_tok_state_e;

  lc_tok_state_e state;
  lc_tok_state_e next_state;
  logic [7:0] cmd;
  logic [2:0] cnt;
  logic [2:0] next_cnt;
  logic [4:0] next_idx;
  logic [15:0] crc16;
  logic [7:0] crc8;
  logic [7:0] tx_byte;
  logic feed16;
  logic [7:0] feed_byte;
  logic [63:0] id_word;
  logic [63:0] cnt_word;

  assign id_word = {8'h00, id_serial};
  assign cnt_word = {secret_count, page_count};

  // ****************************************
  // Frame sequencing
  // ****************************************
  // Next state, byte to answer and byte to feed
  always_comb
  begin
    next_state = state;
    next_cnt = cnt;
    next_idx = sp_addr;
    tx_byte = lc_pkg::IDLE_READ_BYTE;
    feed16 = 1'b0;
    feed_byte = 8'h00;
    case (state)
      ST_IDLE:
        if (lk.m2s_valid)
        begin
          next_cnt = 3'h0;
          if (lk.m2s_byte == lc_pkg::CMD_READ_ID)
            next_state = ST_ID_SEND;
          else if (lk.m2s_byte == lc_pkg::CMD_WRITE_PAD || lk.m2s_byte == lc_pkg::CMD_READ_PAD ||
                   lk.m2s_byte == lc_pkg::CMD_SIGNED_PAGE || lk.m2s_byte == lc_pkg::CMD_HASH)
            next_state = ST_TA_LO;
        end
      ST_TA_LO:
        if (lk.m2s_valid)
        begin
          feed16 = 1'b1;
          feed_byte = lk.m2s_byte;
          next_idx = lk.m2s_byte[4:0];
          next_state = ST_TA_HI;
        end
      ST_TA_HI:
        if (lk.m2s_valid)
        begin
          feed16 = 1'b1;
          feed_byte = lk.m2s_byte;
          case (cmd)
            lc_pkg::CMD_WRITE_PAD: next_state = ST_WR_DATA;
            lc_pkg::CMD_READ_PAD: next_state = ST_RD_ES;
            lc_pkg::CMD_SIGNED_PAGE: next_state = ST_PG_DATA;
            default: next_state = ST_HS_CTRL;
          endcase
        end
      ST_WR_DATA:
        if (lk.m2s_valid)
        begin
          feed16 = 1'b1;
          feed_byte = lk.m2s_byte;
          if (sp_addr == lc_pkg::PAD_LAST_OFFSET)
            next_state = ST_SEND_CRC;
          else
            next_idx = sp_addr + 5'h01;
        end
      ST_RD_ES:
        if (lk.rd_req)
        begin
          tx_byte = es_byte;
          feed16 = 1'b1;
          feed_byte = es_byte;
          next_state = ST_RD_DATA;
        end
      ST_RD_DATA:
        if (lk.rd_req)
        begin
          tx_byte = conceal_flag ? lc_pkg::CONCEAL_BYTE : sp_rdata;
          feed16 = 1'b1;
          feed_byte = tx_byte;
          if (sp_addr == lc_pkg::PAD_LAST_OFFSET)
            next_state = ST_SEND_CRC;
          else
            next_idx = sp_addr + 5'h01;
        end
      ST_PG_DATA:
        if (lk.rd_req)
        begin
          tx_byte = mem_rdata;
          feed16 = 1'b1;
          feed_byte = mem_rdata;
          if (sp_addr == lc_pkg::PAD_LAST_OFFSET)
            next_state = ST_PG_CNT;
          else
            next_idx = sp_addr + 5'h01;
        end
      ST_PG_CNT:
        if (lk.rd_req)
        begin
          tx_byte = cnt_word[{cnt, 3'b000} +: 8];
          feed16 = 1'b1;
          feed_byte = tx_byte;
          if (cnt == lc_pkg::COUNTER_LAST_INDEX)
          begin
            next_cnt = 3'h0;
            next_state = ST_SEND_CRC;
          end
          else
            next_cnt = cnt + 3'h1;
        end
      ST_HS_CTRL:
        if (lk.m2s_valid)
        begin
          feed16 = 1'b1;
          feed_byte = lk.m2s_byte;
          next_state = ST_SEND_CRC;
        end
      ST_SEND_CRC:
        if (lk.rd_req)
        begin
          tx_byte = cnt[0] ? ~crc16[15:8] : ~crc16[7:0];
          if (cnt == lc_pkg::CHECK_HIGH_INDEX)
            next_state = ST_DONE;
          else
            next_cnt = cnt + 3'h1;
        end
      ST_ID_SEND:
        if (lk.rd_req)
        begin
          tx_byte = (cnt == lc_pkg::ID_CHECK_INDEX) ? crc8 : id_word[{cnt, 3'b000} +: 8];
          if (cnt == lc_pkg::ID_CHECK_INDEX)
            next_state = ST_DONE;
          else
            next_cnt = cnt + 3'h1;
        end
      ST_DONE:
        next_state = ST_DONE;
      default:
        next_state = ST_IDLE;
    endcase
  end

  // State, counters and pad offset; bus reset aborts any frame
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state <= ST_IDLE;
      cnt <= 3'h0;
      sp_addr <= 5'h00;
      cmd <= 8'h00;
    end
    else if (lk.bus_reset)
    begin
      state <= ST_IDLE;
      cnt <= 3'h0;
    end
    else
    begin
      state <= next_state;
      cnt <= next_cnt;
      sp_addr <= next_idx;
      if (state == ST_IDLE && lk.m2s_valid)
        cmd <= lk.m2s_byte;
    end
  end

  // ****************************************
  // Check generators
  // ****************************************
  // Frame check: cleared and loaded with the command in one step
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      crc16 <= lc_pkg::CRC16_CLEAR;
    else if (state == ST_IDLE && lk.m2s_valid)
      crc16 <= lc_pkg::crc16_byte(lc_pkg::CRC16_CLEAR, lk.m2s_byte);
    else if (feed16)
      crc16 <= lc_pkg::crc16_byte(crc16, feed_byte);
  end

  // Identity check over the seven lower bytes as they go out
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      crc8 <= lc_pkg::CRC8_CLEAR;
    else if (state == ST_IDLE)
      crc8 <= lc_pkg::CRC8_CLEAR;
    else if (state == ST_ID_SEND && lk.rd_req && cnt != lc_pkg::ID_CHECK_INDEX)
      crc8 <= lc_pkg::crc8_byte(crc8, tx_byte);
  end

  // ****************************************
  // Outputs
  // ****************************************
  // Answer every read request one cycle later
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      lk.s2m_valid <= 1'b0;
      lk.s2m_byte <= 8'h00;
    end
    else
    begin
      lk.s2m_valid <= lk.rd_req;
      lk.s2m_byte <= tx_byte;
    end
  end

  // Pad store, suppressed while concealed
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      sp_we <= 1'b0;
      sp_waddr <= 5'h00;
      sp_wdata <= 8'h00;
    end
    else
    begin
      sp_we <= state == ST_WR_DATA && lk.m2s_valid && !conceal_flag && !lk.bus_reset;
      sp_waddr <= sp_addr;
      sp_wdata <= lk.m2s_byte;
    end
  end

  // Page address follows the target address and each page byte read
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      mem_addr <= 16'h0000;
    else if (state == ST_TA_LO && lk.m2s_valid)
      mem_addr[7:0] <= lk.m2s_byte;
    else if (state == ST_TA_HI && lk.m2s_valid)
      mem_addr[15:8] <= lk.m2s_byte;
    else if (state == ST_PG_DATA && lk.rd_req)
      mem_addr <= mem_addr + 16'h0001;
  end

  // Hash start with its control byte
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      hash_go <= 1'b0;
      hash_ctrl <= 8'h00;
    end
    else
    begin
      hash_go <= state == ST_HS_CTRL && lk.m2s_valid && !lk.bus_reset;
      if (state == ST_HS_CTRL && lk.m2s_valid)
        hash_ctrl <= lk.m2s_byte;
    end
  end

endmodule

`default_nettype wire

/* File: lc_master.sv */
// Master end: drives frames and verifies identity and frame checks
`timescale 1ns/1ps
`default_nettype none

module lc_master (
  input wire logic sys_clk, // 200 MHz clock
  input wire logic resetn, // Async reset, active low
  lc_link_if.master lk, // Link to token
  input wire logic u_bus_reset, // Abort frame, clear checks
  input wire logic u_clear, // Clear both checks
  input wire logic u_tx_valid, // Send one byte
  input wire logic [7:0] u_tx_byte, // Byte to send
  input wire logic u_rx_req, // Read one data byte
  input wire logic u_chk16_req, // Read and verify frame check
  input wire logic u_chk8_req, // Read and verify identity check
  output var logic busy, // Request in progress
  output var logic u_rx_valid, // Read byte ready, pulse
  output var logic [7:0] u_rx_byte, // Read byte
  output var logic chk_done, // Verify finished, pulse
  output var logic chk_ok // Last verify matched
);

  // ****************************************
  // State
  // ****************************************
  typedef enum {H_IDLE, H_RX, H_C16_LO, H_C16_HI, H_C8} lc_mst_state_e;

  lc_mst_state_e state;
  logic [15:0] crc16;
  logic [7:0] crc8;
  logic [15:0] ref16;
  logic [7:0] ref8;
  logic [7:0] lo_byte;
  logic take_idle;

  assign take_idle = state == H_IDLE && !busy;

  // ****************************************
  // Request handling
  // ****************************************
  // Link strobes, user answers and verify results
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state <= H_IDLE;
      busy <= 1'b0;
      lk.bus_reset <= 1'b0;
      lk.m2s_valid <= 1'b0;
      lk.m2s_byte <= 8'h00;
      lk.rd_req <= 1'b0;
      u_rx_valid <= 1'b0;
      u_rx_byte <= 8'h00;
      chk_done <= 1'b0;
      chk_ok <= 1'b0;
      ref16 <= 16'h0000;
      ref8 <= 8'h00;
      lo_byte <= 8'h00;
    end
    else
    begin
      lk.bus_reset <= 1'b0;
      lk.m2s_valid <= 1'b0;
      lk.rd_req <= 1'b0;
      u_rx_valid <= 1'b0;
      chk_done <= 1'b0;
      busy <= 1'b0;
      case (state)
        H_IDLE:
          if (u_bus_reset || u_clear)
            lk.bus_reset <= u_bus_reset; // A clear alone only restarts the checks
          else if (u_tx_valid)
          begin
            lk.m2s_valid <= 1'b1;
            lk.m2s_byte <= u_tx_byte;
          end
          else if (u_rx_req)
          begin
            lk.rd_req <= 1'b1;
            busy <= 1'b1;
            state <= H_RX;
          end
          else if (u_chk16_req)
          begin
            lk.rd_req <= 1'b1;
            busy <= 1'b1;
            ref16 <= ~crc16;
            state <= H_C16_LO;
          end
          else if (u_chk8_req)
          begin
            lk.rd_req <= 1'b1;
            busy <= 1'b1;
            ref8 <= crc8;
            state <= H_C8;
          end
        H_RX:
        begin
          busy <= !lk.s2m_valid;
          if (lk.s2m_valid)
          begin
            u_rx_valid <= 1'b1;
            u_rx_byte <= lk.s2m_byte;
            state <= H_IDLE;
          end
        end
        H_C16_LO:
        begin
          busy <= 1'b1;
          if (lk.s2m_valid)
          begin
            lo_byte <= lk.s2m_byte;
            lk.rd_req <= 1'b1;
            state <= H_C16_HI;
          end
        end
        H_C16_HI:
        begin
          busy <= !lk.s2m_valid;
          if (lk.s2m_valid)
          begin
            chk_done <= 1'b1;
            chk_ok <= {lk.s2m_byte, lo_byte} == ref16;
            state <= H_IDLE;
          end
        end
        H_C8:
        begin
          busy <= !lk.s2m_valid;
          if (lk.s2m_valid)
          begin
            chk_done <= 1'b1;
            chk_ok <= lk.s2m_byte == ref8;
            state <= H_IDLE;
          end
        end
        default:
          state <= H_IDLE;
      endcase
    end
  end

  // ****************************************
  // Check generators
  // ****************************************
  // Frame check over every byte sent and every data byte read
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      crc16 <= lc_pkg::CRC16_CLEAR;
    else if (take_idle && (u_bus_reset || u_clear))
      crc16 <= lc_pkg::CRC16_CLEAR;
    else if (take_idle && u_tx_valid)
      crc16 <= lc_pkg::crc16_byte(crc16, u_tx_byte);
    else if (state == H_RX && lk.s2m_valid)
      crc16 <= lc_pkg::crc16_byte(crc16, lk.s2m_byte);
  end

  // Identity check over the data bytes read
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      crc8 <= lc_pkg::CRC8_CLEAR;
    else if (take_idle && (u_bus_reset || u_clear))
      crc8 <= lc_pkg::CRC8_CLEAR;
    else if (state == H_RX && lk.s2m_valid)
      crc8 <= lc_pkg::crc8_byte(crc8, lk.s2m_byte);
  end

endmodule

`default_nettype wire

/* File: lc_link_props.sv */
// Link-side checker for identity and frame check bytes
`timescale 1ns/1ps
`default_nettype none

module lc_link_props (
  input wire logic sys_clk, // Clock
  input wire logic resetn, // Async reset, active low
  input wire logic bus_reset, // Frame abort pulse
  input wire logic m2s_valid, // Byte to token
  input wire logic [7:0] m2s_byte, // Byte to token
  input wire logic rd_req, // Read request
  input wire logic s2m_valid, // Read answer
  input wire logic [7:0] s2m_byte // Read byte
);
  // ********
  // Frame tracking
  // ********
  logic [7:0] cmd;
  logic [6:0] ofs;
  logic [6:0] wr_cnt;
  logic [6:0] rd_cnt;
  logic [6:0] lo_pos;
  logic [15:0] fc;
  logic [15:0] c8;

  // One byte into a reflected check, LSB first
  function automatic logic [15:0] step(input logic [15:0] c, input logic [7:0] d,
    input logic [15:0] p);
    logic [15:0] r;
    r = c;
    for (int i = 0; i < 8; i++)
      r = (r >> 1) ^ ((r[0] ^ d[i]) ? p : 16'h0000);
    return r;
  endfunction

  // Read position of the low check byte, zero while none is due
  always_comb
  begin
    case (cmd)
      lc_pkg::CMD_WRITE_PAD: lo_pos = (wr_cnt > 7'h03 && ofs + wr_cnt >= 7'h23) ? 7'h01 : 7'h00;
      lc_pkg::CMD_READ_PAD: lo_pos = 7'h22 - ofs;
      lc_pkg::CMD_SIGNED_PAGE: lo_pos = 7'h29 - ofs;
      lc_pkg::CMD_HASH: lo_pos = (wr_cnt > 7'h03) ? 7'h01 : 7'h00;
      default: lo_pos = 7'h00;
    endcase
  end

  // Running checks: frame check up to its check bytes, identity check over the first seven reads
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      {cmd, ofs, wr_cnt, rd_cnt, fc, c8} <= '0;
    else if (bus_reset)
      {cmd, ofs, wr_cnt, rd_cnt, fc, c8} <= '0;
    else
    begin
      if (m2s_valid)
      begin
        wr_cnt <= wr_cnt + 7'h01;
        fc <= step(fc, m2s_byte, 16'ha001); // x^16+x^15+x^2+1
        if (wr_cnt == 7'h00)
          cmd <= m2s_byte;
        if (wr_cnt == 7'h01)
          ofs <= {2'b00, m2s_byte[4:0]};
      end
      if (s2m_valid)
      begin
        rd_cnt <= rd_cnt + 7'h01;
        if (lo_pos == 7'h00 || rd_cnt + 7'h01 < lo_pos)
          fc <= step(fc, s2m_byte, 16'ha001);
        if (rd_cnt < 7'h07)
          c8 <= step(c8, s2m_byte, 16'h008c); // x^8+x^5+x^4+1
      end
    end
  end

  // ********
  // Assertions
  // ********
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!resetn);

  read_answer_a: assert property (rd_req |=> s2m_valid)
    else $error("read request not answered next cycle");
  no_spurious_a: assert property (!rd_req |=> !s2m_valid)
    else $error("read answer without request");
  reset_pulse_a: assert property (bus_reset |=> !bus_reset)
    else $error("frame abort longer than one cycle");
  id_check_a: assert property (s2m_valid && cmd == lc_pkg::CMD_READ_ID && rd_cnt == 7'h07
    |-> s2m_byte == c8[7:0]) else $error("identity check byte wrong");
  id_idle_a: assert property (s2m_valid && cmd == lc_pkg::CMD_READ_ID && rd_cnt > 7'h07
    |-> s2m_byte == 8'hff) else $error("identity frame sends past check byte");
  check_low_a: assert property (s2m_valid && lo_pos != 7'h00 && rd_cnt + 7'h01 == lo_pos
    |-> s2m_byte == ~fc[7:0]) else $error("low frame check byte wrong");
  check_high_a: assert property (s2m_valid && lo_pos != 7'h00 && rd_cnt == lo_pos
    |-> s2m_byte == ~fc[15:8]) else $error("high frame check byte wrong");
  done_idle_a: assert property (s2m_valid && lo_pos != 7'h00 && rd_cnt > lo_pos
    |-> s2m_byte == 8'hff) else $error("bytes sent after frame check");
endmodule

`default_nettype wire

/* File: lc_link_crc8_crc16_generator_test.sv */
// Self-checking bench: master and token ends joined by the link
`timescale 1ns/1ps
`default_nettype none

module lc_link_crc8_crc16_generator_test;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic u_bus_reset, u_clear, u_tx_valid, u_rx_req, u_chk16_req, u_chk8_req, conceal_flag;
  logic busy, u_rx_valid, chk_done, chk_ok, sp_we, hash_go;
  logic [7:0] u_tx_byte, u_rx_byte, es_byte, sp_rdata, mem_rdata, sp_wdata, hash_ctrl;
  logic [7:0] o, lo, hi, d;
  logic [4:0] sp_addr, sp_waddr;
  logic [15:0] mem_addr, e16, t;
  logic [31:0] page_count, secret_count;
  logic [55:0] id_serial;
  logic [7:0] pad [32];
  logic [7:0] exp_pad [32];
  int bad_count, checked, seed, we_n, go_n, n0;

  // ********
  // Clock, pad and page models
  // ********
  always #2.5 sys_clk = ~sys_clk;
  assign sp_rdata = pad[sp_addr];
  assign mem_rdata = mem_addr[7:0] ^ mem_addr[15:8];

  // Pad writes and hash starts, counted
  always @(posedge sys_clk)
  begin
    if (sp_we === 1'b1)
    begin
      pad[sp_waddr] <= sp_wdata;
      we_n++;
    end
    if (hash_go === 1'b1)
      go_n++;
  end

  lc_link_if lk_if ();
  lc_master lc_master_inst (.sys_clk(sys_clk), .resetn(resetn), .lk(lk_if),
    .u_bus_reset(u_bus_reset), .u_clear(u_clear), .u_tx_valid(u_tx_valid),
    .u_tx_byte(u_tx_byte), .u_rx_req(u_rx_req), .u_chk16_req(u_chk16_req),
    .u_chk8_req(u_chk8_req), .busy(busy), .u_rx_valid(u_rx_valid), .u_rx_byte(u_rx_byte),
    .chk_done(chk_done), .chk_ok(chk_ok));
  lc_token lc_token_inst (.sys_clk(sys_clk), .resetn(resetn), .lk(lk_if),
    .id_serial(id_serial), .conceal_flag(conceal_flag), .es_byte(es_byte),
    .sp_rdata(sp_rdata), .mem_rdata(mem_rdata), .page_count(page_count),
    .secret_count(secret_count), .sp_addr(sp_addr), .sp_we(sp_we), .sp_waddr(sp_waddr),
    .sp_wdata(sp_wdata), .mem_addr(mem_addr), .hash_go(hash_go), .hash_ctrl(hash_ctrl));
  lc_link_props lc_link_props_inst (.sys_clk(sys_clk), .resetn(resetn),
    .bus_reset(lk_if.bus_reset), .m2s_valid(lk_if.m2s_valid), .m2s_byte(lk_if.m2s_byte),
    .rd_req(lk_if.rd_req), .s2m_valid(lk_if.s2m_valid), .s2m_byte(lk_if.s2m_byte));

  // ********
  // Bench tasks
  // ********
  function automatic logic [15:0] step(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c;
    for (int i = 0; i < 8; i++)
      r = (r >> 1) ^ ((r[0] ^ b[i]) ? 16'ha001 : 16'h0000);
    return r;
  endfunction

  task automatic end_of_test;
    if (bad_count == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] want);
    checked++;
    if (got !== want)
    begin
      bad_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, want);
    end
  endtask

  // Bounded wait: 0 master free, 1 read byte ready, 2 verify done
  task automatic wait_val(input int sel);
    int n;
    n = 0;
    while (!((sel == 0) ? busy === 1'b0 : (sel == 1) ? u_rx_valid === 1'b1 : chk_done === 1'b1))
    begin
      @(posedge sys_clk);
      #1;
      n++;
      if (n > 40)
      begin
        bad_count++;
        $display("CHECK FAILED at %0t: wait %0d got %h expected %h", $time, sel, n, 40);
        end_of_test();
      end
    end
  endtask

  // One-cycle request: 0 abort, 1 clear, 2 read, 3 frame verify, 4 identity verify
  task automatic pulse(input int sel);
    wait_val(0);
    @(posedge sys_clk);
    case (sel)
      0: u_bus_reset <= 1'b1;
      1: u_clear <= 1'b1;
      2: u_rx_req <= 1'b1;
      3: u_chk16_req <= 1'b1;
      default: u_chk8_req <= 1'b1;
    endcase
    @(posedge sys_clk);
    {u_bus_reset, u_clear, u_rx_req, u_chk16_req, u_chk8_req} <= 5'h00;
    #1;
  endtask

  task automatic tx(input logic [7:0] b);
    wait_val(0);
    @(posedge sys_clk);
    u_tx_valid <= 1'b1;
    u_tx_byte <= b;
    @(posedge sys_clk);
    u_tx_valid <= 1'b0;
    #1;
    e16 = step(e16, b);
  endtask

  task automatic rx(input logic [7:0] want);
    pulse(2);
    wait_val(1);
    cmp(u_rx_byte, want);
    e16 = step(e16, want);
  endtask

  task automatic verify(input int sel, input logic want);
    pulse(sel);
    wait_val(2);
    cmp(chk_ok, want);
  endtask

  task automatic frame(input logic [7:0] c);
    pulse(0);
    e16 = 16'h0000;
    tx(c);
    tx(lo);
    tx(hi);
  endtask

  // ********
  // Main sequence
  // ********
  initial
  begin
    {u_bus_reset, u_clear, u_tx_valid, u_rx_req, u_chk16_req, u_chk8_req, conceal_flag} = '0;
    {bad_count, checked, we_n, go_n} = '0;
    seed = 72;
    u_tx_byte = 8'h00;
    id_serial = 56'({$random(seed), $random(seed)});
    es_byte = 8'($random(seed));
    page_count = $random(seed);
    secret_count = $random(seed);
    for (int i = 0; i < 32; i++)
    begin
      pad[i] = 8'(i * 7);
      exp_pad[i] = pad[i];
    end
    repeat (16) @(posedge sys_clk);
    resetn <= 1'b1;
    // Identity: clean, then with a clear mid-frame
    for (int j = 0; j < 2; j++)
    begin
      pulse(0);
      tx(lc_pkg::CMD_READ_ID);
      for (int i = 0; i < 7; i++)
      begin
        if (j == 1 && i == 3)
          pulse(1);
        rx(id_serial[8 * i +: 8]);
      end
      verify(4, j == 0);
      rx(8'hff);
    end
    // Pad writes from several offsets, one concealed
    for (int k = 0; k < 4; k++)
    begin
      o = (k == 0) ? 8'h1e : (k == 1) ? 8'h00 : 8'($random(seed)) & 8'h1f;
      lo = (8'($random(seed)) & 8'he0) | o;
      hi = 8'($random(seed));
      conceal_flag <= (k == 2);
      n0 = we_n;
      frame(lc_pkg::CMD_WRITE_PAD);
      for (int i = int'(o); i < 32; i++)
      begin
        d = 8'($random(seed));
        if (k != 2)
          exp_pad[i] = d;
        tx(d);
      end
      t = ~e16;
      rx(t[7:0]);
      rx(t[15:8]);
      rx(8'hff);
      cmp(we_n - n0, (k == 2) ? 0 : 32 - int'(o));
    end
    // Write that stops short of the last offset
    conceal_flag <= 1'b0;
    lo = 8'h10;
    frame(lc_pkg::CMD_WRITE_PAD);
    tx(8'h3c);
    tx(8'hc3);
    exp_pad[16] = 8'h3c;
    exp_pad[17] = 8'hc3;
    rx(8'hff);
    // Pad reads, open and concealed
    for (int k = 0; k < 2; k++)
    begin
      o = (k == 0) ? 8'h00 : 8'($random(seed)) & 8'h1f;
      lo = (8'($random(seed)) & 8'he0) | o;
      conceal_flag <= (k == 1);
      frame(lc_pkg::CMD_READ_PAD);
      rx(es_byte);
      for (int i = int'(o); i < 32; i++)
        rx((k == 1) ? 8'hff : exp_pad[i]);
      verify(3, 1'b1);
      rx(8'hff);
    end
    // Signed page read with both counters
    conceal_flag <= 1'b0;
    o = 8'h13;
    lo = 8'h53;
    hi = 8'($random(seed));
    frame(lc_pkg::CMD_SIGNED_PAGE);
    for (int i = int'(o); i < 32; i++)
      rx({lo[7:5], 5'(i)} ^ hi);
    for (int i = 0; i < 8; i++)
      rx((i < 4) ? page_count[8 * i +: 8] : secret_count[8 * (i - 4) +: 8]);
    verify(3, 1'b1);
    // Hash frames with random control bytes
    for (int k = 0; k < 3; k++)
    begin
      lo = 8'($random(seed));
      d = 8'($random(seed));
      n0 = go_n;
      frame(lc_pkg::CMD_HASH);
      tx(d);
      verify(3, 1'b1);
      cmp(go_n - n0, 1);
      cmp(hash_ctrl, d);
    end
    end_of_test();
  end
endmodule

`default_nettype wire
